//--- image_sensor_readout_control.sv
// Top of the sensor control and readout logic: pixel-array drive and address sequencing.
// Assumes the controller drives all pins asynchronously; the 25 MHz clock oversamples them.
`timescale 1ns/1ps
module image_sensor_readout_control
  import sensor_readout_pkg::*;
(
  // Clocking
  input wire logic clk,
  input wire logic rst,
  input wire logic clkEn,
  // Controller pins
  input wire ctrl_pins_t pins,
  // Pixel-array internal drives
  output logic memNodeHigh,
  output reset_level_t resetLevel,
  output logic integrating,
  // Readout addressing
  output logic [ADDR_W-1:0] rowAddr,
  output logic [ADDR_W-1:0] colAddr,
  output logic colReading,
  output logic pixelPhase,
  output logic windowed,
  // Flags
  output scan_flags_t flags
);
  ctrl_pins_t syncPins;
  ctrl_pins_t prevPins_r;
  logic [START_W-1:0] colStart;
  logic [START_W-1:0] rowStart;
  logic serialCheck;

  // Every pin passes two flip-flops before use
  pin_sync #(.WIDTH($bits(ctrl_pins_t))) u_sync (
    .clk(clk),
    .rst(rst),
    .clkEn(clkEn),
    .asyncIn(pins),
    .syncOut(syncPins)
  );

  serial_config u_cfg (
    .clk(clk),
    .rst(rst),
    .clkEn(clkEn),
    .serData(syncPins.serialData),
    .serClk(syncPins.serialClk),
    .serLoad(syncPins.serialLoad),
    .colStart(colStart),
    .rowStart(rowStart),
    .serialCheck(serialCheck)
  );

  // Edge detection on synchronised pins
  // Previous pins reset low, the idle level of every pin, so no false edge follows reset
  logic frameSyncRise;
  logic lineSyncRise;
  logic lineStepRise;
  logic pixelRise;
  logic pixelFall;
  assign frameSyncRise = syncPins.frameSync & ~prevPins_r.frameSync;
  assign lineSyncRise = syncPins.lineSync & ~prevPins_r.lineSync;
  assign lineStepRise = syncPins.lineStepClk & ~prevPins_r.lineStepClk;
  assign pixelRise = syncPins.pixelClk & ~prevPins_r.pixelClk;
  assign pixelFall = ~syncPins.pixelClk & prevPins_r.pixelClk;

  // Pixel-array drive state
  logic memNodeHigh_r;
  logic memNodeHigh_nxt;
  reset_level_t resetLevel_r;
  reset_level_t resetLevel_nxt;
  logic integrating_r;
  logic integrating_nxt;

  // Full reset wins over dual slope; integration starts once full reset is seen low
  always_comb begin
    memNodeHigh_nxt = syncPins.memoryBoostCtrl;
    if (syncPins.fullReset) begin
      resetLevel_nxt = LVL_FULL;
    end else if (syncPins.dualSlopeReset) begin
      resetLevel_nxt = LVL_PARTIAL;
    end else begin
      resetLevel_nxt = LVL_NONE;
    end
    integrating_nxt = integrating_r;
    if (syncPins.fullReset) begin
      integrating_nxt = 1'b0;
    end else if (prevPins_r.fullReset) begin
      integrating_nxt = 1'b1;
    end
  end

  // Pixel-array registers; previous pins feed the edge detectors
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      memNodeHigh_r <= 1'b0;
      resetLevel_r <= LVL_NONE;
      integrating_r <= 1'b0;
      prevPins_r <= '0;
    end else if (clkEn) begin
      memNodeHigh_r <= memNodeHigh_nxt;
      resetLevel_r <= resetLevel_nxt;
      integrating_r <= integrating_nxt;
      prevPins_r <= syncPins;
    end
  end

  // Readout sequencer states
  typedef enum logic [1:0] {
    LINE_IDLE = 2'b01,
    LINE_READ = 2'b10
  } line_state_t;

  line_state_t lineState_r;
  line_state_t lineState_nxt;
  logic [ADDR_W-1:0] rowAddr_r;
  logic [ADDR_W-1:0] rowAddr_nxt;
  logic [ADDR_W-1:0] colAddr_r;
  logic [ADDR_W-1:0] colAddr_nxt;
  logic phase_r;
  logic phase_nxt;
  logic windowed_r;
  logic windowed_nxt;
  logic eol_r;
  logic eol_nxt;
  logic eof_r;
  logic eof_nxt;
  logic check_r;

  // Frame sync dominates the row counter; holding it over a step edge reloads again
  // so the start row is what remains once sync drops.
  always_comb begin
    rowAddr_nxt = rowAddr_r;
    colAddr_nxt = colAddr_r;
    lineState_nxt = lineState_r;
    phase_nxt = phase_r;
    windowed_nxt = windowed_r;
    eol_nxt = 1'b0;
    eof_nxt = 1'b0;
    if (syncPins.frameSync) begin
      if (frameSyncRise || lineStepRise) begin
        rowAddr_nxt = {rowStart, 1'b0};
        windowed_nxt = (rowStart != '0) || (colStart != '0);
      end
    end else if (lineStepRise) begin
      rowAddr_nxt = ADDR_W'(rowAddr_r + 1'b1);
      lineState_nxt = LINE_IDLE;
      if (!windowed_r && rowAddr_r == ADDR_W'(LAST_ROW)) begin
        eof_nxt = 1'b1;
      end
    end
    case (lineState_r)
      LINE_IDLE: begin
        if (lineSyncRise) begin
          colAddr_nxt = {colStart, 1'b0};
          phase_nxt = 1'b0;
          lineState_nxt = LINE_READ;
        end
      end
      LINE_READ: begin
        if (lineSyncRise) begin
          colAddr_nxt = {colStart, 1'b0};
          phase_nxt = 1'b0;
        end else if (pixelRise) begin
          phase_nxt = 1'b0;
        end else if (pixelFall) begin
          phase_nxt = 1'b1;
          if (colAddr_r >= ADDR_W'(LAST_COL - 1)) begin
            lineState_nxt = LINE_IDLE;
            eol_nxt = !windowed_r;
          end else begin
            colAddr_nxt = ADDR_W'(colAddr_r + 2'd2);
          end
        end
      end
      default: lineState_nxt = LINE_IDLE;
    endcase
  end

  // Sequencer registers; the end-of-line and end-of-frame flags are one-cycle pulses
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lineState_r <= LINE_IDLE;
      rowAddr_r <= '0;
      colAddr_r <= '0;
      phase_r <= 1'b0;
      windowed_r <= 1'b0;
      eol_r <= 1'b0;
      eof_r <= 1'b0;
      check_r <= 1'b0;
    end else if (clkEn) begin
      lineState_r <= lineState_nxt;
      rowAddr_r <= rowAddr_nxt;
      colAddr_r <= colAddr_nxt;
      phase_r <= phase_nxt;
      windowed_r <= windowed_nxt;
      eol_r <= eol_nxt;
      eof_r <= eof_nxt;
      check_r <= serialCheck;
    end
  end

  // Outputs straight from flip-flops
  assign memNodeHigh = memNodeHigh_r;
  assign resetLevel = resetLevel_r;
  assign integrating = integrating_r;
  assign rowAddr = rowAddr_r;
  assign colAddr = colAddr_r;
  assign colReading = lineState_r[1]; // One-hot read bit, straight from the state flop
  assign pixelPhase = phase_r;
  assign windowed = windowed_r;
  assign flags = '{endOfLine: eol_r, endOfFrame: eof_r, serialCheck: check_r};

  // Helper sequences: full reset held then released; a line step; a pixel fall in a line
  sequence s_reset_release;
    syncPins.fullReset ##1 !syncPins.fullReset;
  endsequence

  sequence s_step_edge;
    clkEn && !syncPins.frameSync && lineStepRise;
  endsequence

  sequence s_pixel_fall;
    clkEn && lineState_r == LINE_READ && !lineSyncRise && pixelFall;
  endsequence

  // Pixel-array drive
  a_mem_follow: assert property (@(posedge clk) disable iff (rst)
    clkEn |=> memNodeHigh_r == $past(syncPins.memoryBoostCtrl))
    else $error("memory node level does not follow boost control");
  a_full_prio: assert property (@(posedge clk) disable iff (rst)
    clkEn && syncPins.fullReset && syncPins.dualSlopeReset |=> resetLevel_r == LVL_FULL)
    else $error("full reset lost priority");
  a_partial_level: assert property (@(posedge clk) disable iff (rst)
    clkEn && !syncPins.fullReset && syncPins.dualSlopeReset |=> resetLevel_r == LVL_PARTIAL)
    else $error("dual-slope reset did not apply the partial level");
  a_level_idle: assert property (@(posedge clk) disable iff (rst)
    clkEn && !syncPins.fullReset && !syncPins.dualSlopeReset |=> resetLevel_r == LVL_NONE)
    else $error("reset level applied with both controls low");
  a_integ_clear: assert property (@(posedge clk) disable iff (rst)
    clkEn && syncPins.fullReset |=> !integrating_r)
    else $error("integrating while full reset held");
  a_integ_start: assert property (@(posedge clk) disable iff (rst)
    clkEn ##0 s_reset_release ##0 clkEn |=> integrating_r)
    else $error("integration did not start on reset release");

  // Row addressing; a held frame sync keeps reloading the start row
  a_row_load: assert property (@(posedge clk) disable iff (rst)
    clkEn && syncPins.frameSync && frameSyncRise |=> rowAddr_r == {$past(rowStart), 1'b0})
    else $error("row address not loaded on frame sync");
  a_row_reload: assert property (@(posedge clk) disable iff (rst)
    clkEn && syncPins.frameSync && lineStepRise |=> rowAddr_r == {$past(rowStart), 1'b0})
    else $error("row address not reloaded while frame sync held");
  a_window_mark: assert property (@(posedge clk) disable iff (rst)
    clkEn && frameSyncRise |=> windowed_r == ($past(rowStart) != '0 || $past(colStart) != '0))
    else $error("window mode not taken from the start values");
  a_row_step: assert property (@(posedge clk) disable iff (rst)
    s_step_edge |=> rowAddr_r == ADDR_W'($past(rowAddr_r) + 1))
    else $error("row did not advance");
  a_line_close: assert property (@(posedge clk) disable iff (rst)
    s_step_edge ##0 !lineSyncRise |=> lineState_r == LINE_IDLE)
    else $error("line readout survived a line step");
  a_eof_last: assert property (@(posedge clk) disable iff (rst)
    s_step_edge ##0 (!windowed_r && rowAddr_r == ADDR_W'(LAST_ROW))
      |=> eof_r && rowAddr_r == '0)
    else $error("end of frame missing at the last row");
  a_eof_window: assert property (@(posedge clk) disable iff (rst)
    windowed_r |-> !eof_nxt)
    else $error("end of frame flagged while windowed");
  a_eof_pulse: assert property (@(posedge clk) disable iff (rst)
    clkEn && eof_r |=> !eof_r)
    else $error("end of frame longer than one cycle");

  // Column addressing and pixel pairs
  a_col_load: assert property (@(posedge clk) disable iff (rst)
    clkEn && lineSyncRise |=> colAddr_r == {$past(colStart), 1'b0})
    else $error("column address not loaded on line sync");
  a_col_even: assert property (@(posedge clk) disable iff (rst)
    clkEn && lineSyncRise |=> colAddr_r[0] == 1'b0)
    else $error("odd column start");
  a_col_step: assert property (@(posedge clk) disable iff (rst)
    s_pixel_fall ##0 (colAddr_r < ADDR_W'(LAST_COL - 1))
      |=> colAddr_r == ADDR_W'($past(colAddr_r) + 2))
    else $error("column did not step by one pair");
  a_phase_rise: assert property (@(posedge clk) disable iff (rst)
    clkEn && lineState_r == LINE_READ && !lineSyncRise && pixelRise |=> !phase_r)
    else $error("first pixel of pair not shown on clock high");
  a_phase_fall: assert property (@(posedge clk) disable iff (rst)
    s_pixel_fall |=> phase_r)
    else $error("second pixel of pair not shown on clock low");
  a_eol_last: assert property (@(posedge clk) disable iff (rst)
    s_pixel_fall ##0 (!windowed_r && colAddr_r >= ADDR_W'(LAST_COL - 1))
      |=> eol_r && lineState_r == LINE_IDLE)
    else $error("end of line missing at the last column");
  a_eol_window: assert property (@(posedge clk) disable iff (rst)
    windowed_r && $stable(windowed_r) |-> !eol_nxt)
    else $error("end of line flagged while windowed");
  a_eol_pulse: assert property (@(posedge clk) disable iff (rst)
    clkEn && eol_r |=> !eol_r)
    else $error("end of line longer than one cycle");

  // Serial check bit reaches its flag one cycle later
  a_check_out: assert property (@(posedge clk) disable iff (rst)
    clkEn |=> check_r == $past(serialCheck))
    else $error("serial check flag does not follow the register");
endmodule

//--- sensor_readout_pkg.sv
// Package for the image sensor readout control block: constants and carriers.
// Assumes a single 25 MHz clock domain; all sensor pins arrive asynchronously.
// Behaviour
// - Memory-node level follows memory boost control: low for 0, high for 1.
// - Full reset and dual-slope reset together apply the full reset level.
// - Full reset holds photodiode reset; its release starts integration.
// - Frame sync starts frame readout, loads row address, marks frame end.
// - Each line-step clock rising edge advances row selection by one; while frame sync is high the code reloads the start row instead.
// - Line sync starts line read at column register, marks line end.
// - Serial data shifts into serial register on serial clock edges.
// - Loaded configuration takes effect on serial load strobe rising edge.
// - End-of-line flag at last column in full scan, never when windowed.
// - End-of-frame flag at last row in full scan, never when windowed.
// - Serial check output lets controller verify data passed the register.
// - Window start addresses load into address registers on sync pulses.
// - Start registers are 10 bits; start positions have granularity two.
// - Start value is half the position; one means line 2, column 2.
// - Single-output mode shows two pixels per pixel clock: high then low.
package sensor_readout_pkg;
  localparam int START_W = 10;
  localparam int ADDR_W = 11;
  localparam int SER_W = 2 * START_W;
  localparam int LAST_COL = 2047;
  localparam int LAST_ROW = 2047;
  // Serial word layout: column start in low bits, row start above
  localparam int COL_START_LSB = 0;
  localparam int ROW_START_LSB = START_W;
  localparam logic [START_W-1:0] COL_START_RST = 10'h000;
  localparam logic [START_W-1:0] ROW_START_RST = 10'h000;
  localparam int SYNC_STAGES = 2;

  // Pixel-array reset level selection
  typedef enum logic [2:0] {
    LVL_NONE = 3'b001,
    LVL_PARTIAL = 3'b010,
    LVL_FULL = 3'b100
  } reset_level_t;

  // Raw pin group from the controller
  typedef struct packed {
    logic fullReset;
    logic dualSlopeReset;
    logic memoryBoostCtrl;
    logic frameSync;
    logic lineStepClk;
    logic lineSync;
    logic pixelClk;
    logic serialData;
    logic serialClk;
    logic serialLoad;
  } ctrl_pins_t;

  // Flags back to the controller
  typedef struct packed {
    logic endOfLine;
    logic endOfFrame;
    logic serialCheck;
  } scan_flags_t;
endpackage

//--- pin_sync.sv
// Two-stage synchroniser for a vector of asynchronous sensor pins.
// Assumes the pins are quasi-static relative to the 25 MHz clock.
`timescale 1ns/1ps
module pin_sync
  import sensor_readout_pkg::*;
#(
  parameter int WIDTH = 1
) (
  // Clocking
  input wire logic clk,
  input wire logic rst,
  input wire logic clkEn,
  // Data
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] meta_nxt;
  logic [WIDTH-1:0] sync_r;
  logic [WIDTH-1:0] sync_nxt;

  // Refuse an empty pin vector when the design is elaborated
  if (WIDTH < 1) begin : g_width_check
    $error("pin_sync width must be positive");
  end

  // First stage feeds only the second
  always_comb begin
    meta_nxt = clkEn ? asyncIn : meta_r;
    sync_nxt = clkEn ? meta_r : sync_r;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign syncOut = sync_r;
endmodule

//--- serial_config.sv
// Serial configuration register: shift on serial clock, commit on load strobe.
// Assumes synchronised pins; edges are detected on the second sync stage.
`timescale 1ns/1ps
module serial_config
  import sensor_readout_pkg::*;
(
  // Clocking
  input wire logic clk,
  input wire logic rst,
  input wire logic clkEn,
  // Synchronised serial pins
  input wire logic serData,
  input wire logic serClk,
  input wire logic serLoad,
  // Committed window starts and check bit
  output logic [START_W-1:0] colStart,
  output logic [START_W-1:0] rowStart,
  output logic serialCheck
);
  logic [SER_W-1:0] shift_r;
  logic [SER_W-1:0] shift_nxt;
  logic [START_W-1:0] colStart_r;
  logic [START_W-1:0] colStart_nxt;
  logic [START_W-1:0] rowStart_r;
  logic [START_W-1:0] rowStart_nxt;
  logic serClkPrev_r;
  logic serLoadPrev_r;
  logic check_r;
  logic check_nxt;
  logic shiftEdge;
  logic loadEdge;

  assign shiftEdge = serClk & ~serClkPrev_r;
  assign loadEdge = serLoad & ~serLoadPrev_r;

  // Shift MSB first; check bit is the bit falling out, so data can be looped back
  always_comb begin
    shift_nxt = shift_r;
    colStart_nxt = colStart_r;
    rowStart_nxt = rowStart_r;
    check_nxt = check_r;
    if (shiftEdge) begin
      shift_nxt = {shift_r[SER_W-2:0], serData};
      check_nxt = shift_r[SER_W-1];
    end
    if (loadEdge) begin
      colStart_nxt = shift_r[COL_START_LSB +: START_W];
      rowStart_nxt = shift_r[ROW_START_LSB +: START_W];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      shift_r <= '0;
      colStart_r <= COL_START_RST;
      rowStart_r <= ROW_START_RST;
      check_r <= 1'b0;
      serClkPrev_r <= 1'b0;
      serLoadPrev_r <= 1'b0;
    end else if (clkEn) begin
      shift_r <= shift_nxt;
      colStart_r <= colStart_nxt;
      rowStart_r <= rowStart_nxt;
      check_r <= check_nxt;
      serClkPrev_r <= serClk;
      serLoadPrev_r <= serLoad;
    end
  end

  assign colStart = colStart_r;
  assign rowStart = rowStart_r;
  assign serialCheck = check_r;

  a_load_commit: assert property (@(posedge clk) disable iff (rst)
    clkEn && loadEdge |=> colStart_r == $past(shift_r[COL_START_LSB +: START_W]))
    else $error("column start not committed on load edge");
  a_shift_in: assert property (@(posedge clk) disable iff (rst)
    clkEn && shiftEdge |=> shift_r[0] == $past(serData))
    else $error("serial bit not shifted in");
endmodule

//--- controller_model.sv
// Behavioural timing controller that drives the sensor control pins.
// Assumes the caller is on a rising clock edge when it enters any task.
`timescale 1ns/1ps
module controller_model
  import sensor_readout_pkg::*;
(
  // Clocking
  input wire logic clk,
  // Sensor pins
  output ctrl_pins_t pins
);
  // All controls idle low from time zero, resets inactive
  initial pins = '0;
  // Column sample-hold, precharge, no-row-select and averaging drive only the analog
  // column chain; this pin group leaves them out

  task automatic hold(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Pixel-array controls; both resets are active high
  task automatic setArray(input logic fr, input logic ds, input logic mb);
    @(posedge clk);
    pins.fullReset <= fr;
    pins.dualSlopeReset <= ds;
    pins.memoryBoostCtrl <= mb;
  endtask

  // One serial bit; data is settled well before the clock rises
  task automatic sendBit(input logic b);
    pins.serialData <= b;
    pins.serialClk <= 1'b0;
    hold(4);
    pins.serialClk <= 1'b1;
    hold(6);
  endtask

  task automatic loadStrobe();
    pins.serialClk <= 1'b0;
    pins.serialLoad <= 1'b1;
    hold(4);
    pins.serialLoad <= 1'b0;
    hold(4);
  endtask

  // Frame sync spans one line-step rise so the row register reloads
  task automatic frameStart();
    pins.frameSync <= 1'b1;
    hold(4);
    pins.lineStepClk <= 1'b1;
    hold(4);
    pins.frameSync <= 1'b0;
    pins.lineStepClk <= 1'b0;
    hold(4);
  endtask

  // Slow pulses: five clocks per phase, since the block oversamples the pins;
  // the pixel clock therefore runs far below its nominal rate here
  task automatic pulse(input ctrl_pins_t m, input int n);
    repeat (n) begin
      pins <= pins | m;
      hold(5);
      pins <= pins & ~m;
      hold(5);
    end
  endtask
endmodule

//--- image_sensor_readout_control_tb.sv
// Self-checking bench for the sensor readout control block.
// Assumes the controller model drives every pin; clkEn drops once to test the freeze.
`timescale 1ns/1ps
module image_sensor_readout_control_tb;
  import sensor_readout_pkg::*;

  typedef struct packed {
    logic fr;
    logic ds;
    logic mb;
    reset_level_t lvl;
    logic mem;
    logic integ;
  } row_t;

  localparam ctrl_pins_t STEP = 10'h020;
  localparam ctrl_pins_t LSYNC = 10'h010;
  localparam ctrl_pins_t PIX = 10'h008;
  // Row overhead of 200 ns at 40 ns per clock
  localparam int ROW_OVERHEAD = 5;

  logic clk;
  logic rst;
  logic clkEn;
  ctrl_pins_t pins;
  logic memNodeHigh;
  reset_level_t resetLevel;
  logic integrating;
  logic [ADDR_W-1:0] rowAddr;
  logic [ADDR_W-1:0] colAddr;
  logic colReading;
  logic pixelPhase;
  logic windowed;
  scan_flags_t flags;
  logic [SER_W-1:0] word;
  int nMismatch = 0;
  int checked = 0;
  int cycles = 0;
  int eolCount = 0;
  int eofCount = 0;

  // Array-control cases; integration starts once full reset has dropped
  row_t rows [5] = '{
    '{1'b0, 1'b0, 1'b0, LVL_NONE, 1'b0, 1'b0},
    '{1'b1, 1'b0, 1'b1, LVL_FULL, 1'b1, 1'b0},
    '{1'b1, 1'b1, 1'b0, LVL_FULL, 1'b0, 1'b0},
    '{1'b0, 1'b1, 1'b1, LVL_PARTIAL, 1'b1, 1'b1},
    '{1'b0, 1'b0, 1'b0, LVL_NONE, 1'b0, 1'b1}
  };

  image_sensor_readout_control dut (
    .clk(clk),
    .rst(rst),
    .clkEn(clkEn),
    .pins(pins),
    .memNodeHigh(memNodeHigh),
    .resetLevel(resetLevel),
    .integrating(integrating),
    .rowAddr(rowAddr),
    .colAddr(colAddr),
    .colReading(colReading),
    .pixelPhase(pixelPhase),
    .windowed(windowed),
    .flags(flags)
  );

  controller_model ctl (
    .clk(clk),
    .pins(pins)
  );

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      nMismatch++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic closeOut();
    $display("checks %0d mismatches %0d", checked, nMismatch);
    if (nMismatch == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // Flag pulses last one cycle, so count them; also cut a hang short
  always @(posedge clk) begin
    cycles++;
    if (flags.endOfLine === 1'b1) eolCount++;
    if (flags.endOfFrame === 1'b1) eofCount++;
    // Tests take about 62,000 cycles, flush included
    if (cycles == 80000) begin
      nMismatch++;
      closeOut();
    end
  end

  initial begin
    rst = 1'b1;
    clkEn = 1'b1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check("resetLevel", 16'(resetLevel), 16'(LVL_NONE));
    check("rowAddr", 16'(rowAddr), 16'h0000);
    // Power-up flush; the full-frame row run wraps once with one end of frame
    ctl.pulse(PIX | STEP, 1024);
    ctl.pulse(STEP, 1024);
    check("eofCount", 16'(eofCount), 16'h0001);
    check("rowAddr", 16'(rowAddr), 16'h0000);
    for (int i = 0; i < 5; i++) begin
      ctl.setArray(rows[i].fr, rows[i].ds, rows[i].mb);
      ctl.hold(6);
      check("resetLevel", 16'(resetLevel), 16'(rows[i].lvl));
      check("memNodeHigh", 16'(memNodeHigh), 16'(rows[i].mem));
      check("integrating", 16'(integrating), 16'(rows[i].integ));
    end
    // Window start one in both axes: row 2, column 2
    word = {10'h001, 10'h001};
    for (int i = SER_W - 1; i >= 0; i--) ctl.sendBit(word[i]);
    ctl.loadStrobe();
    ctl.frameStart();
    check("rowAddr", 16'(rowAddr), 16'h0002);
    check("windowed", 16'(windowed), 16'h0001);
    ctl.pulse(STEP, 1);
    check("rowAddr", 16'(rowAddr), 16'h0003);
    // Enable low: a whole line-step pulse must leave the row untouched
    clkEn <= 1'b0;
    ctl.pulse(STEP, 1);
    clkEn <= 1'b1;
    ctl.hold(ROW_OVERHEAD);
    check("rowAddr", 16'(rowAddr), 16'h0003);
    ctl.pulse(LSYNC, 1);
    check("colAddr", 16'(colAddr), 16'h0002);
    check("colReading", 16'(colReading), 16'h0001);
    check("pixelPhase", 16'(pixelPhase), 16'h0000);
    ctl.pulse(PIX, 1);
    check("colAddr", 16'(colAddr), 16'h0004);
    check("pixelPhase", 16'(pixelPhase), 16'h0001);
    // Windowed line stops at the last column and goes idle without a flag
    ctl.pulse(PIX, 1023);
    check("eolCount", 16'(eolCount), 16'h0000);
    check("colReading", 16'(colReading), 16'h0000);
    // Loop-back: shifting zeros returns the previous word, first bit first
    for (int i = SER_W - 1; i >= 0; i--) begin
      ctl.sendBit(1'b0);
      check("serialCheck", 16'(flags.serialCheck), 16'(word[i]));
    end
    ctl.loadStrobe();
    ctl.frameStart();
    check("rowAddr", 16'(rowAddr), 16'h0000);
    check("windowed", 16'(windowed), 16'h0000);
    ctl.hold(ROW_OVERHEAD);
    ctl.pulse(LSYNC, 1);
    ctl.pulse(PIX, 1024);
    check("eolCount", 16'(eolCount), 16'h0001);
    ctl.pulse(STEP, 2048);
    check("eofCount", 16'(eofCount), 16'h0002);
    closeOut();
  end
endmodule
